// *** rtl/gpc_params.svh ***
/*
  constants of the pin 3/4 control block: serial word layout, register
  addresses, reset values, write masks and field positions.
  assumes inclusion by bare name from the design files.
*/
`ifndef GPC_PARAMS_SVH
`define GPC_PARAMS_SVH

`define GPC_WORD_W        16
`define GPC_CNT_W         4
`define GPC_CNT_LAST      4'hf
`define GPC_EXT_PREFIX    4'hf
`define GPC_CTRL1_PREFIX  4'h0
`define GPC_PIN34_WADDR   4'h1
`define GPC_DATA_WADDR    4'h2
`define GPC_PIN34_RADDR   5'h1c
`define GPC_DATA_RADDR    5'h1d
`define GPC_RADDR_RESET   5'h00
`define GPC_PIN34_RESET   8'h00
`define GPC_DATA_RESET    8'h00
`define GPC_PIN34_WMASK   8'hf7
`define GPC_DATA_WMASK    8'hf0
`define GPC_RADDR_MSB     11
`define GPC_RADDR_LSB     7
`define GPC_P4_ALEN       0
`define GPC_P4_DIR        1
`define GPC_P4_POL        2
`define GPC_P3_ALEN       4
`define GPC_P3_DIR        5
`define GPC_P3_POL        6
`define GPC_P3_FSEL       7
`define GPC_D_PIN4        4
`define GPC_D_PIN3        5
`define GPC_D_PIN2        6
`define GPC_D_PIN1        7
`define GPC_SYNC_W        5
`define GPC_SYNC_RESET    5'h01

`endif

// *** rtl/gpc_pkg.sv ***
/*
  types of the pin 3/4 control block.
  assumes nothing of its surroundings.
*/
package gpc_pkg;
  typedef enum logic [1:0] {
    GPC_IDLE  = 2'b01,
    GPC_SHIFT = 2'b10
  } gpc_ser_state_e;
  typedef logic [7:0] gpc_reg_t;
endpackage

// *** rtl/gpc_sync.sv ***
/*
  three-stage synchroniser with agreement filter for a group of pin inputs.
  assumes inputs are asynchronous to mclk.
*/
`timescale 1ns/1ps
`include "gpc_params.svh"
module gpc_sync #(
  parameter int         W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         mclk,
  input  wire logic         resetn,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] level
);
  logic [W-1:0] s1_q, s2_q, s3_q, filt_q;
  logic [W-1:0] filt_d;

  // a change counts once stages two and three agree
  always_comb begin
    for (int i = 0; i < W; i++) begin
      filt_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : filt_q[i];
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      s1_q   <= RST_VAL;
      s2_q   <= RST_VAL;
      s3_q   <= RST_VAL;
      filt_q <= RST_VAL;
    end else begin
      s1_q   <= async_in;
      s2_q   <= s1_q;
      s3_q   <= s2_q;
      filt_q <= filt_d;
    end
  end

  assign level = filt_q;
endmodule // gpc_sync

// *** rtl/gpc_serial.sv ***
/*
  serial word shifter: 16-bit frames, msb first, sampled on sclk rise.
  assumes synchronised, filtered cs_n, sclk and din levels.
*/
`timescale 1ns/1ps
`include "gpc_params.svh"
module gpc_serial (
  input  wire logic                     mclk,
  input  wire logic                     resetn,
  input  wire logic                     cs_n_lvl,
  input  wire logic                     sclk_lvl,
  input  wire logic                     din_lvl,
  input  wire logic [`GPC_WORD_W-1:0]   tx_word,
  output logic                          word_valid,
  output logic      [`GPC_WORD_W-1:0]   rx_word,
  output logic                          dout,
  output logic                          dout_oe
);
  gpc_pkg::gpc_ser_state_e state_q, state_d;
  logic [`GPC_WORD_W-1:0] rx_q, rx_d, tx_q, tx_d, word_q, word_d;
  logic [`GPC_CNT_W-1:0]  cnt_q, cnt_d;
  logic                   sclk_prev_q, valid_q, valid_d;
  logic                   rise;

  assign rise = sclk_lvl & ~sclk_prev_q;

  always_comb begin
    state_d = state_q;
    rx_d    = rx_q;
    tx_d    = tx_q;
    cnt_d   = cnt_q;
    word_d  = word_q;
    valid_d = 1'b0;
    unique case (state_q)
      gpc_pkg::GPC_IDLE: begin
        if (!cs_n_lvl) begin
          state_d = gpc_pkg::GPC_SHIFT;
          tx_d    = tx_word;
          cnt_d   = '0;
        end
      end
      gpc_pkg::GPC_SHIFT: begin
        if (cs_n_lvl) begin
          state_d = gpc_pkg::GPC_IDLE;
        end else if (rise) begin
          rx_d  = {rx_q[`GPC_WORD_W-2:0], din_lvl};
          tx_d  = {tx_q[`GPC_WORD_W-2:0], 1'b0};
          cnt_d = cnt_q + 4'h1;
          if (cnt_q == `GPC_CNT_LAST) begin
            valid_d = 1'b1;
            word_d  = rx_d;
          end
        end
      end
      default: state_d = gpc_pkg::GPC_IDLE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      state_q     <= gpc_pkg::GPC_IDLE;
      rx_q        <= '0;
      tx_q        <= '0;
      cnt_q       <= '0;
      word_q      <= '0;
      valid_q     <= 1'b0;
      sclk_prev_q <= 1'b0;
    end else begin
      state_q     <= state_d;
      rx_q        <= rx_d;
      tx_q        <= tx_d;
      cnt_q       <= cnt_d;
      word_q      <= word_d;
      valid_q     <= valid_d;
      sclk_prev_q <= sclk_lvl;
    end
  end

  assign word_valid = valid_q;
  assign rx_word    = word_q;
  assign dout       = tx_q[`GPC_WORD_W-1];
  assign dout_oe    = (state_q == gpc_pkg::GPC_SHIFT);
endmodule // gpc_serial

// *** rtl/gpc_top.sv ***
/*
  pin 3/4 control and pin data registers behind the serial interface.
  assumes a host framing 16-bit words on cs_n/sclk/din and an outer pad
  that resolves the three-signal pins.
*/
// Operation
// - the pin 3/4 control register is written at extended nibble 0001, read at address 11100, resets to zero.
// - the pin data register is written at extended nibble 0010, read at address 11101, resets to zero.
// - control bit 0 set lets pin 4 drive the alert output, clear masks it.
// - control bit 1 sets pin 4 direction, 0 output and 1 input.
// - control bit 2 sets pin 4 active level, 0 low and 1 high.
// - control bit 3 and data bits 0 to 3 do nothing and ignore writes.
// - control bit 4 set lets pin 3 drive the alert output, clear masks it.
// - control bit 5 sets pin 3 direction, 0 output and 1 input.
// - control bit 6 sets pin 3 active level, 0 low and 1 high.
// - control bit 7 picks analog input three when 0 and general pin 3 when 1.
// - data bits 4 to 7 hold pins 4, 3, 2 and 1 and are readable and writable.
`timescale 1ns/1ps
`include "gpc_params.svh"
module gpc_top (
  input  wire logic mclk,
  input  wire logic resetn,
  input  wire logic cs_n,
  input  wire logic sclk,
  input  wire logic din,
  output logic      dout,
  output logic      dout_oe,
  input  wire logic pin3_in,
  output logic      pin3_out,
  output logic      pin3_oe,
  input  wire logic pin4_in,
  output logic      pin4_out,
  output logic      pin4_oe,
  output logic      aux_input_three_sel,
  output logic      pin1_data,
  output logic      pin2_data,
  output logic      alert
);
  logic [`GPC_SYNC_W-1:0]  sync_lvl;
  logic                    word_valid;
  logic [`GPC_WORD_W-1:0]  rx_word;
  logic [`GPC_WORD_W-1:0]  tx_word;
  gpc_pkg::gpc_reg_t       ctrl_q, ctrl_d, data_q, data_d, rd_val;
  logic [4:0]              raddr_q, raddr_d;
  logic                    alert_q, alert_d;
  logic                    p3_lvl, p4_lvl;
  logic                    p3_gpio, p3_is_in, p4_is_in, p3_drive, p4_drive;
  logic                    p3_active, p4_active;

  gpc_sync #(
    .W       (`GPC_SYNC_W),
    .RST_VAL (`GPC_SYNC_RESET)
  ) u_sync (
    .mclk     (mclk),
    .resetn   (resetn),
    .async_in ({pin4_in, pin3_in, din, sclk, cs_n}),
    .level    (sync_lvl)
  );

  assign p3_lvl = sync_lvl[3];
  assign p4_lvl = sync_lvl[4];

  gpc_serial u_serial (
    .mclk       (mclk),
    .resetn     (resetn),
    .cs_n_lvl   (sync_lvl[0]),
    .sclk_lvl   (sync_lvl[1]),
    .din_lvl    (sync_lvl[2]),
    .tx_word    (tx_word),
    .word_valid (word_valid),
    .rx_word    (rx_word),
    .dout       (dout),
    .dout_oe    (dout_oe)
  );

  // pin roles
  assign p3_gpio  = ctrl_q[`GPC_P3_FSEL];
  assign p4_is_in = ctrl_q[`GPC_P4_DIR];
  assign p3_is_in = ctrl_q[`GPC_P3_DIR];
  assign p4_drive = ~p4_is_in;
  assign p3_drive = p3_gpio & ~p3_is_in;
  assign p4_active = (p4_lvl == ctrl_q[`GPC_P4_POL]);
  assign p3_active = (p3_lvl == ctrl_q[`GPC_P3_POL]);

  // register writes and read address load
  always_comb begin
    ctrl_d  = ctrl_q;
    data_d  = data_q;
    raddr_d = raddr_q;
    if (word_valid) begin
      if (rx_word[15:12] == `GPC_EXT_PREFIX) begin
        if (rx_word[11:8] == `GPC_PIN34_WADDR) begin
          ctrl_d = rx_word[7:0] & `GPC_PIN34_WMASK;
        end else if (rx_word[11:8] == `GPC_DATA_WADDR) begin
          data_d = rx_word[7:0] & `GPC_DATA_WMASK;
        end
      end else if (rx_word[15:12] == `GPC_CTRL1_PREFIX) begin
        raddr_d = rx_word[`GPC_RADDR_MSB:`GPC_RADDR_LSB];
      end
    end
  end

  // read value: input pins return their sampled level
  always_comb begin
    rd_val = 8'h00;
    if (raddr_q == `GPC_PIN34_RADDR) begin
      rd_val = ctrl_q;
    end else if (raddr_q == `GPC_DATA_RADDR) begin
      rd_val = data_q;
      if (p4_is_in) begin
        rd_val[`GPC_D_PIN4] = p4_lvl;
      end
      if (p3_gpio && p3_is_in) begin
        rd_val[`GPC_D_PIN3] = p3_lvl;
      end
    end
  end

  assign tx_word = {8'h00, rd_val};

  // alert from enabled input pins at their active level
  always_comb begin
    alert_d = (ctrl_q[`GPC_P4_ALEN] & p4_is_in & p4_active) |
              (ctrl_q[`GPC_P3_ALEN] & p3_gpio & p3_is_in & p3_active);
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      ctrl_q  <= `GPC_PIN34_RESET;
      data_q  <= `GPC_DATA_RESET;
      raddr_q <= `GPC_RADDR_RESET;
      alert_q <= 1'b0;
    end else begin
      ctrl_q  <= ctrl_d;
      data_q  <= data_d;
      raddr_q <= raddr_d;
      alert_q <= alert_d;
    end
  end

  // output pins drive data by polarity
  assign pin4_out = ~(data_q[`GPC_D_PIN4] ^ ctrl_q[`GPC_P4_POL]);
  assign pin3_out = ~(data_q[`GPC_D_PIN3] ^ ctrl_q[`GPC_P3_POL]);
  assign pin4_oe  = p4_drive;
  assign pin3_oe  = p3_drive;
  assign aux_input_three_sel = ~p3_gpio;
  assign pin1_data = data_q[`GPC_D_PIN1];
  assign pin2_data = data_q[`GPC_D_PIN2];
  assign alert     = alert_q;
endmodule // gpc_top

// *** verif/gpc_checker.sv ***
/* port assertions for gpc_top; assumes one mclk domain and bind at the foot of this file. */
`timescale 1ns/1ps
module gpc_checker (
  input wire logic mclk,
  resetn,
  cs_n,
  sclk,
  din,
  dout,
  dout_oe,
  pin3_in,
  pin3_out,
  pin3_oe,
  pin4_in,
  pin4_out,
  pin4_oe,
  aux_input_three_sel,
  pin1_data,
  pin2_data,
  alert
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  logic [3:0] hi_q;
  logic [3:0] hi_d;
  // cycles since the host last held cs_n low
  always_comb hi_d = !cs_n ? 4'h0 : (hi_q == 4'hf) ? hi_q : hi_q + 4'h1;
  always_ff @(posedge mclk) hi_q <= resetn ? hi_d : 4'hf;
  sequence cs_quiet;
    cs_n [*8];
  endsequence
  sequence sclk_idle;
    (!sclk && $stable(cs_n)) [*8];
  endsequence
  reset_vals_a: assert property (disable iff (1'b0)
    !resetn |=> pin4_oe && pin4_out && !pin3_oe && pin3_out && aux_input_three_sel && !pin1_data && !pin2_data
    && !dout_oe && !alert) else $error("reset values wrong");
  cfg_quiet_a: assert property (
    cs_quiet |-> $stable({pin3_oe, pin3_out, pin4_oe, pin4_out, aux_input_three_sel, pin1_data, pin2_data}))
    else $error("pin setup changed outside a frame");
  func_excl_a: assert property (pin3_oe |-> !aux_input_three_sel) else $error("pin 3 driven as analog");
  alert_src_a: assert property (
    alert |-> $past(!pin4_oe || (!pin3_oe && !aux_input_three_sel))
    || $past(!pin4_oe || (!pin3_oe && !aux_input_three_sel), 2)) else $error("alert with no input pin");
  dout_hold_a: assert property (sclk_idle |-> $stable(dout)) else $error("dout moved without sclk");
  frame_start_a: assert property ($fell(cs_n) |-> ##[2:8] dout_oe) else $error("frame not opened");
  frame_end_a: assert property ($rose(cs_n) |-> ##[1:8] !dout_oe) else $error("frame not closed");
  frame_oe_a: assert property (dout_oe |-> hi_q < 4'ha) else $error("dout enabled outside frame");
endmodule // gpc_checker
bind gpc_top gpc_checker chk_i (.mclk, .resetn, .cs_n, .sclk, .din, .dout, .dout_oe, .pin3_in, .pin3_out,
  .pin3_oe, .pin4_in, .pin4_out, .pin4_oe, .aux_input_three_sel, .pin1_data, .pin2_data, .alert);

// *** verif/gpc_host.sv ***
/* host model on the serial link; assumes sclk idles low and phases of HALF mclk cycles. */
`timescale 1ns/1ps
module gpc_host #(
  parameter int HALF = 10
) (
  input  wire logic mclk,
  output logic      cs_n,
  output logic      sclk,
  output logic      din,
  input  wire logic dout
);
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    din  = 1'b0;
  end
  // one 16-bit frame msb first, dout taken just before each sclk rise
  task automatic frame(input logic [15:0] w, output logic [15:0] r);
    r = 16'h0000;
    @(posedge mclk) cs_n <= 1'b0;
    for (int i = 15; i >= 0; i--) begin
      din <= w[i];
      repeat (HALF) @(posedge mclk);
      r[i] = dout;
      sclk <= 1'b1;
      repeat (HALF) @(posedge mclk);
      sclk <= 1'b0;
    end
    repeat (HALF) @(posedge mclk);
    cs_n <= 1'b1;
    din  <= ~w[0];
    repeat (HALF) @(posedge mclk);
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    logic [15:0] r;
    frame({4'hf, a, d}, r);
  endtask
  task automatic rd(input logic [4:0] a, output logic [7:0] v);
    logic [15:0] r;
    frame({4'h0, a, 7'h00}, r);
    frame(16'h0000, r);
    v = r[7:0];
  endtask
endmodule // gpc_host

// *** verif/tb.sv ***
/* self-checking bench for gpc_top; assumes gpc_host drives the serial link. */
`timescale 1ns/1ps
module tb;
  logic       mclk, resetn, cs_n, sclk, din, dout, dout_oe, e3, e4, pin3_in, pin4_in;
  logic       pin3_out, pin3_oe, pin4_out, pin4_oe, aux_input_three_sel, pin1_data, pin2_data, alert;
  logic [7:0] s, c, d, v;
  logic       dout_pad;
  logic [7:0] corner [4] = '{8'h00, 8'hff, 8'h08, 8'hd2};
  int         error_cnt, num_checks, cyc;
  assign pin3_in = (pin3_oe === 1'b1) ? pin3_out : e3;
  assign pin4_in = (pin4_oe === 1'b1) ? pin4_out : e4;
  // a released data line shows the inverse, so a read outside the frame fails
  assign dout_pad = (dout_oe === 1'b1) ? dout : ~dout;
  gpc_top uut (.mclk, .resetn, .cs_n, .sclk, .din, .dout, .dout_oe, .pin3_in, .pin3_out, .pin3_oe, .pin4_in,
    .pin4_out, .pin4_oe, .aux_input_three_sel, .pin1_data, .pin2_data, .alert);
  gpc_host host (.mclk, .cs_n, .sclk, .din, .dout(dout_pad));
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  function automatic logic [7:0] lfsr(input logic [7:0] x);
    return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
  endfunction
  // input pins read back their pad level
  function automatic logic [7:0] exp_data(input logic [7:0] cf, df, input logic a3, a4);
    logic [7:0] r;
    r = df & 8'hf0;
    if (cf[1]) r[4] = a4;
    if (cf[7] & cf[5]) r[5] = a3;
    return r;
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic results;
    $display("checks=%0d errors=%0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // hold reset 12 cycles, then registers and pins must be back at their reset state
  task automatic reset_check;
    resetn <= 1'b0;
    repeat (12) @(posedge mclk);
    resetn <= 1'b1;
    repeat (8) @(posedge mclk);
    chk({4'h0, pin4_oe, pin4_out, pin3_oe, aux_input_three_sel}, 8'h0d);
    chk({5'h0, pin1_data, pin2_data, alert}, 8'h00);
    host.rd(5'h1c, v);
    chk(v, 8'h00);
    host.rd(5'h1d, v);
    chk(v, 8'h00);
  endtask
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      error_cnt++;
      results();
    end
  end
  initial begin
    e3 = 1'b0;
    e4 = 1'b0;
    error_cnt = 0;
    num_checks = 0;
    cyc = 0;
    s = 8'h12;
    reset_check();
    for (int i = 0; i < 10; i++) begin
      s = lfsr(s);
      c = (i < 4) ? corner[i] : s;
      s = lfsr(s);
      d = (i < 4) ? ~corner[i] : s;
      e3 <= s[2];
      e4 <= s[3];
      host.wr(4'h1, c);
      host.wr(4'h2, d);
      host.rd(5'h1c, v);
      chk(v, c & 8'hf7);
      host.rd(5'h1d, v);
      chk(v, exp_data(c, d, e3, e4));
      chk({7'h0, pin4_oe}, {7'h0, ~c[1]});
      chk({7'h0, pin4_out}, {7'h0, ~(d[4] ^ c[2])});
      chk({6'h0, pin3_oe, aux_input_three_sel}, {6'h0, c[7] & ~c[5], ~c[7]});
      chk({7'h0, pin3_out}, {7'h0, ~(d[5] ^ c[6])});
      chk({6'h0, pin1_data, pin2_data}, {6'h0, d[7], d[6]});
      chk({7'h0, alert}, {7'h0, (c[1] & c[0] & (e4 == c[2])) | (c[7] & c[5] & c[4] & (e3 == c[6]))});
    end
    host.wr(4'h3, 8'hff);
    host.rd(5'h1c, v);
    chk(v, c & 8'hf7);
    host.rd(5'h1b, v);
    chk(v, 8'h00);
    reset_check();
    results();
  end
endmodule // tb
